// file: adc_conversion_sequencer.sv
`timescale 1ns/1ps
module adc_conversion_sequencer #(
  parameter int PIN_CNT = 8
) (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic [adc_seq_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [adc_seq_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             hw_conv_trigger,
  input  wire logic                             stop_enter,
  input  wire logic                             alt_clk_tick,
  input  wire logic                             async_clk_tick,
  input  wire logic                             comparator_hi,
  output logic                                  async_clk_en,
  output logic                                  sample_en,
  output logic                                  conv_active,
  output logic [9:0]                            sar_code,
  output logic                                  conv_irq,
  input  wire logic [PIN_CNT-1:0]               gpio_out,
  input  wire logic [PIN_CNT-1:0]               gpio_oe,
  input  wire logic [PIN_CNT-1:0]               gpio_pullup,
  input  wire logic [PIN_CNT-1:0]               pad_in,
  output logic [PIN_CNT-1:0]                    pad_out,
  output logic [PIN_CNT-1:0]                    pad_oe,
  output logic [PIN_CNT-1:0]                    pad_pullup_en,
  output logic [PIN_CNT-1:0]                    pad_in_en,
  output logic [PIN_CNT-1:0]                    port_rd_data
);
  import adc_seq_pkg::*;

  typedef struct packed {
    state_t             st;
    logic [5:0]         cnt;
    logic [2:0]         div;
    logic               half;
    logic [3:0]         bitn;
    logic [9:0]         sar;
    logic               first;
    logic               conv_irq_enable;
    logic               continuous_enable;
    logic               conv_complete_flag;
    logic [4:0]         ch;
    logic               trg;
    logic               compare_enable;
    logic               acfgt;
    logic [7:0]         cfg;
    logic [1:0]         cvh;
    logic [7:0]         cvl;
    logic [9:0]         res;
    logic [PIN_CNT-1:0] pins;
    logic               hi_rd;
    logic               t1;
    logic               t2;
    logic               t3;
    logic               aw_got;
    logic [7:0]         awa;
    logic               w_got;
    logic [7:0]         wd;
    logic               wstb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [7:0]         rdata;
    logic [1:0]         rresp;
    logic [7:0]         cych;
  } ctl_t;

  ctl_t q_r;
  ctl_t q_nxt;

  function automatic logic [7:0] word(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic [2:0] div_mask(input logic [1:0] d);
    return 3'((4'h1 << d) - 4'h1);
  endfunction

  function automatic state_t first_state(input logic [1:0] src);
    return (src == SRC_ASYNC) ? S_START : S_SETB;
  endfunction

  logic [1:0]  src;
  logic        ten;
  logic        busy;
  logic        src_tick;
  logic        converter_clock_tick;
  logic        hw_edge;
  logic        wr_fire;
  logic        rd_fire;
  logic        abort;
  logic        fin;
  logic [5:0]  samp_len;
  logic [5:0]  sar_len;
  logic [9:0]  raw;
  logic [9:0]  cmpv;
  logic [10:0] diff;
  logic        cond;
  logic [9:0]  mask;

  assign src = q_r.cfg[1:0];
  assign ten = q_r.cfg[CFG_MODE+:2] == MODE_10;
  assign busy = q_r.st != S_IDLE;
  assign src_tick = (src == SRC_BUS) ? 1'b1 :
                    (src == SRC_HALF) ? q_r.half :
                    (src == SRC_ALT) ? alt_clk_tick : async_clk_tick;
  assign converter_clock_tick = src_tick && ((q_r.div & div_mask(q_r.cfg[CFG_DIV+:2])) ==
                                  div_mask(q_r.cfg[CFG_DIV+:2]));
  assign hw_edge = q_r.t2 & ~q_r.t3;
  assign wr_fire = q_r.aw_got && q_r.w_got && !q_r.bvalid;
  assign rd_fire = s_axi_arvalid && !q_r.rvalid;
  assign abort = (wr_fire && q_r.wstb && (word(q_r.awa) == OFS_SC1 ||
                  word(q_r.awa) == OFS_SC2 || word(q_r.awa) == OFS_CFG ||
                  word(q_r.awa) == OFS_CV_H || word(q_r.awa) == OFS_CV_L)) ||
                 (stop_enter && src != SRC_ASYNC);
  assign samp_len = q_r.cfg[CFG_LSMP] ? SAMP_LONG : SAMP_SHORT;
  assign sar_len = ten ? SAR_10 : SAR_8;
  assign fin = q_r.st == S_SAR && converter_clock_tick && q_r.cnt == sar_len - 6'h01;
  assign raw = ten ? q_r.sar : {2'b00, q_r.sar[7:0]};
  assign cmpv = ten ? {q_r.cvh, q_r.cvl} : {2'b00, q_r.cvl};
  assign diff = {1'b0, raw} - {1'b0, cmpv};
  assign cond = q_r.acfgt ? !diff[10] : diff[10];
  assign mask = 10'(10'h001 << q_r.bitn);

  always_comb begin
    q_nxt = q_r;
    q_nxt.t1 = hw_conv_trigger;
    q_nxt.t2 = q_r.t1;
    q_nxt.t3 = q_r.t2;
    q_nxt.half = busy ? ~q_r.half : 1'b0;
    q_nxt.div = !busy ? 3'h0 : src_tick ? q_r.div + 3'h1 : q_r.div;
    if (s_axi_awvalid && !q_r.aw_got && !q_r.bvalid) begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_r.w_got && !q_r.bvalid) begin
      q_nxt.w_got = 1'b1;
      q_nxt.wd = s_axi_wdata[7:0];
      q_nxt.wstb = s_axi_wstrb[0];
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (rd_fire) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = RESP_OK;
      q_nxt.rdata = 8'h00;
      unique case (word(s_axi_araddr))
        OFS_SC1: q_nxt.rdata = {q_r.conv_complete_flag, q_r.conv_irq_enable, q_r.continuous_enable, q_r.ch};
        OFS_SC2: q_nxt.rdata = {1'b0, q_r.trg, q_r.compare_enable, q_r.acfgt, 4'h0};
        OFS_CFG: q_nxt.rdata = q_r.cfg;
        OFS_RES_H: begin
          q_nxt.rdata = {6'h00, ten ? q_r.res[9:8] : 2'b00};
          q_nxt.hi_rd = ten;
        end
        OFS_RES_L: begin
          q_nxt.rdata = q_r.res[7:0];
          q_nxt.hi_rd = 1'b0;
          q_nxt.conv_complete_flag = 1'b0;
        end
        OFS_CV_H: q_nxt.rdata = {6'h00, q_r.cvh};
        OFS_CV_L: q_nxt.rdata = q_r.cvl;
        OFS_PINS: q_nxt.rdata = 8'(q_r.pins);
        default: q_nxt.rresp = RESP_ERR;
      endcase
    end
    if (!abort && !busy && q_r.ch != CH_OFF && q_r.trg && hw_edge) begin
      q_nxt.st = first_state(src);
      q_nxt.cnt = 6'h00;
      q_nxt.first = 1'b1;
    end
    if (!abort && busy) begin
      unique case (q_r.st)
        S_START: begin
          q_nxt.cnt = q_r.cnt + 6'h01;
          if (q_r.cnt == START_CYC - 6'h01) begin
            q_nxt.st = S_SETB;
            q_nxt.cnt = 6'h00;
          end
        end
        S_SETB: begin
          q_nxt.cnt = q_r.cnt + 6'h01;
          if (q_r.cnt == FIRST_BUS_CYC - 6'h01) begin
            q_nxt.st = S_SETA;
            q_nxt.cnt = 6'h00;
          end
        end
        S_SETA: begin
          if (converter_clock_tick) begin
            q_nxt.cnt = q_r.cnt + 6'h01;
            if (q_r.cnt == FIRST_CONVERTER_CLOCK_CYC - 6'h01) begin
              q_nxt.st = S_SAMPLE;
              q_nxt.cnt = 6'h00;
            end
          end
        end
        S_SAMPLE: begin
          if (converter_clock_tick) begin
            q_nxt.cnt = q_r.cnt + 6'h01;
            if (q_r.cnt == samp_len - 6'h01) begin
              q_nxt.st = S_SAR;
              q_nxt.cnt = 6'h00;
              q_nxt.sar = ten ? MSB_10 : MSB_8;
              q_nxt.bitn = ten ? NB_10 : NB_8;
            end
          end
        end
        S_SAR: begin
          if (converter_clock_tick) begin
            q_nxt.cnt = q_r.cnt + 6'h01;
            if (q_r.bitn != 4'hf) begin
              q_nxt.sar = (comparator_hi ? q_r.sar : q_r.sar & ~mask) | (mask >> 1);
              q_nxt.bitn = q_r.bitn - 4'h1;
            end
            if (fin) begin
              q_nxt.cnt = 6'h00;
              q_nxt.first = 1'b0;
              q_nxt.st = S_SAMPLE;
              if (q_r.compare_enable && !cond) begin
                q_nxt.st = q_r.continuous_enable ? S_SAMPLE : S_IDLE;
              end else if (ten && q_r.hi_rd) begin
                // Dropped result; a new conversion keeps the old data intact.
                q_nxt.st = S_SAMPLE;
              end else begin
                q_nxt.res = q_r.compare_enable ? (ten ? diff[9:0] : {2'b00, diff[7:0]}) : raw;
                q_nxt.conv_complete_flag = 1'b1;
                q_nxt.st = q_r.continuous_enable ? S_SAMPLE : S_IDLE;
              end
            end
          end
        end
        default: q_nxt.st = S_IDLE;
      endcase
    end
    if (abort) begin
      q_nxt.st = S_IDLE;
      q_nxt.first = 1'b0;
    end
    if (wr_fire) begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = RESP_OK;
      unique case (word(q_r.awa))
        OFS_SC1: begin
          if (q_r.wstb) begin
            q_nxt.conv_irq_enable = q_r.wd[SC1_CONV_IRQ_ENABLE];
            q_nxt.continuous_enable = q_r.wd[SC1_CONTINUOUS_ENABLE];
            q_nxt.ch = q_r.wd[4:0];
            q_nxt.conv_complete_flag = 1'b0;
            if (q_r.wd[4:0] != CH_OFF && !q_r.trg) begin
              q_nxt.st = first_state(src);
              q_nxt.cnt = 6'h00;
              q_nxt.first = 1'b1;
            end
          end
        end
        OFS_SC2: begin
          if (q_r.wstb) begin
            q_nxt.trg = q_r.wd[SC2_TRG];
            q_nxt.compare_enable = q_r.wd[SC2_COMPARE_ENABLE];
            q_nxt.acfgt = q_r.wd[SC2_GT];
          end
        end
        OFS_CFG: begin
          if (q_r.wstb) begin
            q_nxt.cfg = q_r.wd;
          end
        end
        OFS_CV_H: begin
          if (q_r.wstb) begin
            q_nxt.cvh = q_r.wd[1:0];
          end
        end
        OFS_CV_L: begin
          if (q_r.wstb) begin
            q_nxt.cvl = q_r.wd;
          end
        end
        OFS_PINS: begin
          if (q_r.wstb) begin
            q_nxt.pins = PIN_CNT'(q_r.wd);
          end
        end
        OFS_RES_H, OFS_RES_L: q_nxt.bresp = RESP_OK;
        default: q_nxt.bresp = RESP_ERR;
      endcase
    end
    // A restart in mid-conversion must clear the timer too, or the limit check would drift.
    q_nxt.cych = (q_nxt.first && q_nxt.cnt == 6'h00 && (q_nxt.st == S_START ||
                  (q_nxt.st == S_SETB && q_r.st != S_START))) ? 8'h00 : q_r.cych + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '{st: S_IDLE, ch: CH_OFF, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s_axi_awready = !q_r.aw_got && !q_r.bvalid;
  assign s_axi_wready = !q_r.w_got && !q_r.bvalid;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata = {24'h000000, q_r.rdata};
  assign s_axi_rresp = q_r.rresp;
  assign async_clk_en = busy && src == SRC_ASYNC;
  assign sample_en = q_r.st == S_SAMPLE;
  assign conv_active = busy;
  assign sar_code = q_r.sar;
  // The request stays high while the flag and enable are both set.
  assign conv_irq = q_r.conv_complete_flag && q_r.conv_irq_enable;
  assign pad_out = gpio_out;
  assign pad_oe = gpio_oe & ~q_r.pins;
  assign pad_pullup_en = gpio_pullup & ~q_r.pins;
  assign pad_in_en = ~q_r.pins;
  assign port_rd_data = pad_in & ~q_r.pins;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hw_go_s;
    !busy && q_r.trg && q_r.ch != CH_OFF && hw_edge && !abort && !wr_fire;
  endsequence

  pin_iso_a: assert property ((pad_oe & q_r.pins) == '0 && (port_rd_data & q_r.pins) == '0)
    else $error("analog pin not isolated");
  hw_start_a: assert property (hw_go_s |=> busy && q_r.first)
    else $error("hardware edge did not start");
  hw_ignore_a: assert property (q_r.st == S_SAMPLE && !abort && !wr_fire |=>
    q_r.st != S_SETB && q_r.st != S_START)
    else $error("busy conversion restarted");
  done_flag_a: assert property (fin && !abort && !q_r.compare_enable && !(ten && q_r.hi_rd) |=>
    q_r.conv_complete_flag && conv_irq == q_r.conv_irq_enable)
    else $error("completion missing flag");
  block_a: assert property (fin && !abort && !wr_fire && !q_r.compare_enable && ten && q_r.hi_rd
    |=> $stable(q_r.res) && q_r.st == S_SAMPLE)
    else $error("blocked transfer overwrote result");
  cmp_stop_a: assert property (fin && !abort && !wr_fire && q_r.compare_enable && !cond && !q_r.continuous_enable
    |=> q_r.st == S_IDLE && $stable(q_r.res) ##1 !busy || q_r.first)
    else $error("false compare did not stop");
  cfg_abort_a: assert property (abort && !(wr_fire && word(q_r.awa) == OFS_SC1) |=>
    !busy && $stable(q_r.res))
    else $error("abort left conversion running");
  sc1_start_a: assert property (wr_fire && q_r.wstb && word(q_r.awa) == OFS_SC1 &&
    q_r.wd[4:0] != CH_OFF && !q_r.trg |=> busy && q_r.cnt == 6'h00)
    else $error("control one write did not restart");
  first_time_a: assert property (fin && q_r.first && src == SRC_BUS &&
    q_r.cfg[CFG_DIV+:2] == 2'b00 |-> q_r.cych <= 8'h2f)
    else $error("first conversion too slow");
endmodule

// file: adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_SC1 = 8'h00;
  localparam logic [7:0] OFS_SC2 = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_RES_H = 8'h0c;
  localparam logic [7:0] OFS_RES_L = 8'h10;
  localparam logic [7:0] OFS_CV_H = 8'h14;
  localparam logic [7:0] OFS_CV_L = 8'h18;
  localparam logic [7:0] OFS_PINS = 8'h1c;
  localparam int SC1_CONV_COMPLETE_FLAG = 7;
  localparam int SC1_CONV_IRQ_ENABLE = 6;
  localparam int SC1_CONTINUOUS_ENABLE = 5;
  localparam int SC2_TRG = 6;
  localparam int SC2_COMPARE_ENABLE = 5;
  localparam int SC2_GT = 4;
  localparam int CFG_DIV = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE = 2;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int CLK_KHZ = 10000;
  localparam int ASYNC_START_NS = 5000;
  localparam int ASYNC_START_CYC = (ASYNC_START_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [5:0] START_CYC = 6'(ASYNC_START_CYC);
  localparam logic [5:0] FIRST_BUS_CYC = 6'h05;
  localparam logic [5:0] FIRST_CONVERTER_CLOCK_CYC = 6'h03;
  localparam logic [5:0] SAMP_SHORT = 6'h04;
  localparam logic [5:0] SAMP_LONG = 6'h18;
  localparam logic [5:0] SAR_8 = 6'h0d;
  localparam logic [5:0] SAR_10 = 6'h10;
  localparam logic [9:0] MSB_8 = 10'h080;
  localparam logic [9:0] MSB_10 = 10'h200;
  localparam logic [3:0] NB_8 = 4'h7;
  localparam logic [3:0] NB_10 = 4'h9;
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_START  = 3'b001,
    S_SETB   = 3'b010,
    S_SETA   = 3'b011,
    S_SAMPLE = 3'b100,
    S_SAR    = 3'b101
  } state_t;
endpackage

// file: analog_src_model.sv
`timescale 1ns/1ps
// Far side of the sequencer: analog input, trigger source and clock ticks.
module analog_src_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] sar_code,
  input  wire logic [9:0] level,
  input  wire logic       async_clk_en,
  input  wire logic       trig_req,
  output logic            comparator_hi,
  output logic            hw_conv_trigger,
  output logic            async_clk_tick,
  output logic            alt_clk_tick
);
  logic [1:0] alt_cnt_r;
  logic       async_ph_r;

  // An ideal comparator, so a clean approximation returns the level itself.
  assign comparator_hi = (level >= sar_code);
  // The trigger source is unrelated to this clock, so its edges land between clock edges.
  assign #37 hw_conv_trigger = trig_req;
  // The oscillator stands still unless enabled, and ticks every second cycle.
  assign async_clk_tick = async_clk_en & async_ph_r;
  assign alt_clk_tick = (alt_cnt_r == 2'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_cnt_r <= 2'h0;
      async_ph_r <= 1'h0;
    end else begin
      alt_cnt_r <= (alt_cnt_r == 2'h2) ? 2'h0 : alt_cnt_r + 2'h1;
      async_ph_r <= async_clk_en & ~async_ph_r;
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import adc_seq_pkg::*;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, hw_conv_trigger, stop_enter, alt_clk_tick, async_clk_tick;
  logic        comparator_hi, async_clk_en, sample_en, conv_active, conv_irq, trig_req, sa;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, gpio_out, gpio_oe, gpio_pullup, pad_in, d;
  logic [7:0]  pad_out, pad_oe, pad_pullup_en, pad_in_en, port_rd_data, sel;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [9:0]  sar_code, level, last;
  logic [15:0] lf;
  int          miscompares, n_compared, c;
  longint      t0;
  logic [7:0]  cfgs [6] = '{8'h00, 8'h08, 8'h10, 8'h38, 8'h0b, 8'h02};
  // Converter cycles times source cycles per tick, 5 bus cycles, start-up and divider phase.
  int          bnd [6] = '{25, 28, 45, 93, 103, 67};
  logic [7:0]  abt [4] = '{OFS_SC2, OFS_CFG, OFS_CV_H, OFS_CV_L};

  adc_conversion_sequencer u_dut (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_conv_trigger, .stop_enter,
    .alt_clk_tick, .async_clk_tick, .comparator_hi, .async_clk_en, .sample_en,
    .conv_active, .sar_code, .conv_irq, .gpio_out, .gpio_oe, .gpio_pullup, .pad_in,
    .pad_out, .pad_oe, .pad_pullup_en, .pad_in_en, .port_rd_data
  );

  analog_src_model u_src (
    .clk, .rst_n, .sar_code, .level, .async_clk_en, .trig_req, .comparator_hi,
    .hw_conv_trigger, .async_clk_tick, .alt_clk_tick
  );

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    logic aw_ok, w_ok, bv;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      aw_ok = s_axi_awready;
      w_ok = s_axi_wready;
      bv = s_axi_bvalid;
      @(posedge clk);
      n++;
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end while (bv !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    chk(n < 50, 1, "write timeout");
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] rs);
    int n;
    logic ar_ok, rv;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      ar_ok = s_axi_arready;
      rv = s_axi_rvalid;
      v = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      @(posedge clk);
      n++;
      if (ar_ok) s_axi_arvalid <= 1'h0;
    end while (rv !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    chk(n < 50, 1, "read timeout");
  endtask

  task automatic chk_res(input logic [9:0] e);
    logic [7:0] h, l;
    logic [1:0] rs;
    rd(OFS_RES_H, h, rs);
    rd(OFS_RES_L, l, rs);
    chk({h, l}, {22'h0, e}, "result");
  endtask

  // Counts cycles from the start request until the converter goes idle.
  task automatic run_len();
    c = 0;
    sa = 1'h0;
    @(negedge clk);
    while (conv_active !== 1'h1 && c < 4) begin
      @(negedge clk);
      c++;
    end
    while (conv_active === 1'h1 && c < 400) begin
      sa |= async_clk_en;
      @(negedge clk);
      c++;
    end
    chk(c < 400, 1, "conversion hang");
    @(posedge clk);
  endtask

  task automatic wait_irq();
    c = 0;
    @(negedge clk);
    while (conv_irq !== 1'h1 && c < 200) begin
      @(negedge clk);
      c++;
    end
    chk(c < 200, 1, "irq timeout");
    @(posedge clk);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {stop_enter, trig_req, gpio_out, gpio_oe, gpio_pullup, pad_in} = '0;
    s_axi_wstrb = 4'hf;
    level = 10'h000;
    miscompares = 0;
    n_compared = 0;
    lf = 16'h0015;
    rst_n = 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rd(OFS_SC1, d, r);
    chk(d, 32'h1f, "sc1 reset");
    rd(OFS_RES_L, d, r);
    chk(d, 32'h00, "result reset");
    rd(8'h40, d, r);
    chk(r, RESP_ERR, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      sel = lf[7:0];
      gpio_out <= lf[15:8];
      gpio_oe <= ~lf[7:0];
      gpio_pullup <= lf[15:8] ^ 8'h3c;
      pad_in <= ~lf[15:8];
      wr(OFS_PINS, sel);
      chk(pad_out, gpio_out, "pad out");
      chk(pad_oe, gpio_oe & ~sel, "pad oe");
      chk(pad_pullup_en, gpio_pullup & ~sel, "pullup");
      chk(pad_in_en, 8'(~sel), "input buffer");
      chk(port_rd_data, pad_in & ~sel, "port read");
    end
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      level <= cfgs[i][3] ? lf[9:0] : {2'h0, lf[7:0]};
      wr(OFS_CFG, cfgs[i]);
      wr(OFS_SC1, {1'h0, i[0], 6'h00});
      run_len();
      chk(c <= bnd[i] + 1, 1, "conv time");
      chk(sa, cfgs[i][1:0] == SRC_ASYNC, "async clock");
      chk(async_clk_en, 0, "async idle");
      chk(conv_irq, i[0], "irq");
      rd(OFS_SC1, d, r);
      chk(d[7], 1, "flag");
      chk_res(level);
    end
    last = level;
    wr(OFS_CFG, 8'h78);
    for (int k = 0; k < 5; k++) begin
      lf = lfsr(lf);
      level <= lf[9:0];
      wr(OFS_SC1, 8'h00);
      repeat (10) @(posedge clk);
      if (k < 4) wr(abt[k], (k == 1) ? 8'h78 : 8'h00);
      else stop_enter <= 1'h1;
      @(posedge clk);
      stop_enter <= 1'h0;
      repeat (2) @(posedge clk);
      chk(conv_active, 0, "abort");
      chk_res(last);
    end
    wr(OFS_CFG, 8'h08);
    wr(OFS_SC1, 8'h40);
    run_len();
    last = level;
    chk_res(last);
    level <= ~last;
    wr(OFS_SC1, 8'h40);
    rd(OFS_RES_H, d, r);
    repeat (30) @(posedge clk);
    chk(conv_irq, 0, "blocked flag");
    chk(conv_active, 1, "blocked restart");
    rd(OFS_RES_L, d, r);
    chk(d, last[7:0], "blocked data");
    wait_irq();
    chk_res(~last);
    repeat (5) @(posedge clk);
    wr(OFS_SC1, 8'h40);
    run_len();
    chk(c <= 29, 1, "restart time");
    chk(conv_irq, 1, "restart irq");
    // Compare value 0x200 against input 0x080: less-than holds, greater-or-equal fails.
    wr(OFS_CV_H, 8'h02);
    wr(OFS_CV_L, 8'h00);
    level <= 10'h080;
    wr(OFS_SC2, 8'h20);
    wr(OFS_SC1, 8'h40);
    run_len();
    chk(conv_irq, 1, "cmp true flag");
    chk_res(10'h280);
    wr(OFS_SC2, 8'h30);
    wr(OFS_SC1, 8'h40);
    run_len();
    chk(conv_active, 0, "cmp false stop");
    chk(conv_irq, 0, "cmp false flag");
    chk_res(10'h280);
    wr(OFS_SC2, 8'h40);
    wr(OFS_SC1, 8'h40);
    repeat (5) @(posedge clk);
    chk(conv_active, 0, "no sw start");
    lf = lfsr(lf);
    level <= lf[9:0];
    trig_req <= 1'h1;
    repeat (8) @(posedge clk);
    trig_req <= 1'h0;
    repeat (4) @(posedge clk);
    trig_req <= 1'h1;
    run_len();
    repeat (10) @(posedge clk);
    chk(conv_active, 0, "edge ignored");
    chk(conv_irq, 1, "hw irq");
    chk_res(level);
    trig_req <= 1'h0;
    wr(OFS_SC1, 8'h60);
    repeat (3) @(posedge clk);
    trig_req <= 1'h1;
    wait_irq();
    for (int i = 0; i < 3; i++) begin
      t0 = $time;
      trig_req <= i[0];
      rd(OFS_RES_L, d, r);
      chk(d, level[7:0], "cont data");
      wait_irq();
      chk(($time - t0) <= 2100, 1, "cont period");
    end
    wr(OFS_SC1, 8'h1f);
    repeat (30) @(posedge clk);
    chk(conv_active, 0, "disabled");
    final_report();
  end

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
